// *** lpms_top.v ***
`timescale 1ns/1ns
`include "lpms_consts.vh"
module lpms_top #(
   parameter NEXT = `LPMS_EXT_LINES,
   parameter NBKP = `LPMS_BKP_WORDS
) (
   // clock and reset (i_external_reset_pin is the power-on reset of the standby circuitry)
   input  wire                     i_core_clk,
   input  wire                     i_external_reset_pin,
   // core request and configuration
   input  wire                     i_sleep_req,
   input  wire [1:0]               i_mode_sel,
   input  wire                     i_stop_lp_reg,
   input  wire                     i_periph_irq,
   // stop wakeup sources
   input  wire [NEXT-1:0]          i_ext_lines,
   input  wire                     i_supply_voltage_detector,
   input  wire                     i_rtc_alarm,
   input  wire                     i_usb_wakeup,
   // standby exit sources
   input  wire                     i_external_reset_pin_n,
   input  wire                     i_independent_watchdog_rst,
   input  wire                     i_wakeup_pin,
   // backup register port
   input  wire                     i_bkp_wr,
   input  wire [`LPMS_BKP_AW-1:0]  i_bkp_addr,
   input  wire [`LPMS_BKP_DW-1:0]  i_bkp_wdata,
   output wire [`LPMS_BKP_DW-1:0]  o_bkp_rdata,
   // power and clock controls
   output reg                      o_core_halt,
   output reg                      o_core_clk_en,
   output reg                      o_periph_clk_en,
   output reg                      o_pll_en,
   output reg                      o_internal_rc_osc_en,
   output reg                      o_external_crystal_osc_en,
   output reg                      o_core_reg_on,
   output reg                      o_core_reg_lp,
   output reg                      o_core_domain_rst,
   output reg                      o_rtc_wdg_clk_en,
   output reg  [2:0]               o_state,
   output reg                      o_standby_flag
);
   // ---------------------------------------------------------
   // wakeup source gathering
   // ---------------------------------------------------------
   wire [NEXT+2:0]            evt_lines;
   wire                       wakeup_pin_rise;
   wire                       stop_wake;
   wire                       stby_wake;

   assign evt_lines = {i_usb_wakeup, i_rtc_alarm, i_supply_voltage_detector,
                       i_ext_lines};
   assign stop_wake = |evt_lines;

   lpms_edge u_wakeup_pin_edge (
      .i_core_clk (i_core_clk),
      .i_external_reset_pin     (i_external_reset_pin),
      .i_lvl      (i_wakeup_pin),
      .o_rise     (wakeup_pin_rise)
   );

   assign stby_wake = ~i_external_reset_pin_n | i_independent_watchdog_rst
                    | wakeup_pin_rise | i_rtc_alarm;

   // ---------------------------------------------------------
   // backup domain
   // ---------------------------------------------------------
   // held in its own array outside every reset path
   lpms_bkp_mem #(
      .DEPTH (NBKP),
      .AW    (`LPMS_BKP_AW),
      .DW    (`LPMS_BKP_DW)
   ) u_bkp (
      .i_core_clk (i_core_clk),
      .i_wr_en    (i_bkp_wr),
      .i_addr     (i_bkp_addr),
      .i_wdata    (i_bkp_wdata),
      .o_rdata    (o_bkp_rdata)
   );

   // ---------------------------------------------------------
   // entry target decode
   // ---------------------------------------------------------
   // the target is chosen ahead of the request; the spare code
   // falls back to sleep, the mode that loses least
   reg [2:0] entry_state;

   always @* begin
      case (i_mode_sel)
         `LPMS_MODE_STOP: begin
            entry_state = `LPMS_ST_STOP;
         end
         `LPMS_MODE_STANDBY: begin
            entry_state = `LPMS_ST_STANDBY;
         end
         default: begin
            entry_state = `LPMS_ST_SLEEP;
         end
      endcase
   end

   // ---------------------------------------------------------
   // mode sequencer
   // ---------------------------------------------------------
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [3:0] wcnt_reg;
   reg [3:0] wcnt_next;
   reg       from_stby_reg;
   reg       from_stby_next;

   always @* begin
      state_next     = state_reg;
      wcnt_next      = wcnt_reg;
      from_stby_next = from_stby_reg;
      case (state_reg)
         `LPMS_ST_RUN: begin
            if (i_sleep_req) begin
               state_next = entry_state;
            end
         end
         `LPMS_ST_SLEEP: begin
            if (i_periph_irq || stop_wake) begin
               state_next = `LPMS_ST_RUN;
            end
         end
         `LPMS_ST_STOP: begin
            if (stop_wake) begin
               state_next     = `LPMS_ST_WAKE;
               wcnt_next      = `LPMS_WAKE_CYC;
               from_stby_next = 1'b0;
            end
         end
         `LPMS_ST_STANDBY: begin
            if (stby_wake) begin
               state_next     = `LPMS_ST_WAKE;
               wcnt_next      = `LPMS_WAKE_CYC;
               from_stby_next = 1'b1;
            end
         end
         `LPMS_ST_WAKE: begin
            // oscillators restart before the core clocks return
            if (wcnt_reg == 4'h0) begin
               state_next = `LPMS_ST_RUN;
            end else begin
               wcnt_next = wcnt_reg - 4'h1;
            end
         end
         default: begin
            state_next = `LPMS_ST_RUN;
         end
      endcase
   end

   always @(posedge i_core_clk or negedge i_external_reset_pin) begin
      if (!i_external_reset_pin) begin
         state_reg     <= `LPMS_ST_RUN;
         wcnt_reg      <= 4'h0;
         from_stby_reg <= 1'b0;
      end else begin
         state_reg     <= state_next;
         wcnt_reg      <= wcnt_next;
         from_stby_reg <= from_stby_next;
      end
   end

   // ---------------------------------------------------------
   // per-state power and clock settings
   // ---------------------------------------------------------
   // decoded from the next state so each control moves on the same
   // edge as o_state and every output stays a plain flip-flop
   reg       core_halt_next;
   reg       core_clk_en_next;
   reg       periph_clk_en_next;
   reg       pll_en_next;
   reg       rc_osc_en_next;
   reg       xtal_osc_en_next;
   reg       core_reg_on_next;
   reg       core_reg_lp_next;
   reg       dom_rst_next;
   reg       standby_flag_next;
   wire      req_taken;

   // a request is only taken from run; any other time it is ignored
   assign req_taken = i_sleep_req && (state_reg == `LPMS_ST_RUN);

   always @* begin
      // run values; each low-power state below overrides what it stops
      core_halt_next     = 1'b0;
      core_clk_en_next   = 1'b1;
      periph_clk_en_next = 1'b1;
      pll_en_next        = 1'b1;
      rc_osc_en_next     = 1'b1;
      xtal_osc_en_next   = 1'b1;
      core_reg_on_next   = 1'b1;
      core_reg_lp_next   = 1'b0;
      dom_rst_next       = 1'b0;
      case (state_next)
         `LPMS_ST_RUN: begin
            core_halt_next = 1'b0;
         end
         `LPMS_ST_SLEEP: begin
            // only the core stops; peripherals keep their clocks
            core_halt_next = 1'b1;
         end
         `LPMS_ST_STOP: begin
            core_halt_next     = 1'b1;
            core_clk_en_next   = 1'b0;
            periph_clk_en_next = 1'b0;
            pll_en_next        = 1'b0;
            rc_osc_en_next     = 1'b0;
            xtal_osc_en_next   = 1'b0;
            core_reg_lp_next   = i_stop_lp_reg;
         end
         `LPMS_ST_STANDBY: begin
            core_halt_next     = 1'b1;
            core_clk_en_next   = 1'b0;
            periph_clk_en_next = 1'b0;
            pll_en_next        = 1'b0;
            rc_osc_en_next     = 1'b0;
            xtal_osc_en_next   = 1'b0;
            core_reg_on_next   = 1'b0;
            dom_rst_next       = 1'b1;
         end
         `LPMS_ST_WAKE: begin
            // oscillators run again, the multiplier waits for run
            core_halt_next     = 1'b1;
            core_clk_en_next   = 1'b0;
            periph_clk_en_next = 1'b0;
            pll_en_next        = 1'b0;
            if (from_stby_next) begin
               // core domain stays unpowered and in reset until run
               core_reg_on_next = 1'b0;
               dom_rst_next     = 1'b1;
            end
         end
         default: begin
            core_halt_next = 1'b0;
         end
      endcase
   end

   // set wins over a clear in the same cycle, so a request straight
   // back into standby keeps the flag up
   always @* begin
      standby_flag_next = o_standby_flag;
      if (state_next == `LPMS_ST_STANDBY) begin
         standby_flag_next = 1'b1;
      end else if (req_taken) begin
         standby_flag_next = 1'b0;
      end
   end

   // ---------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------
   // core clocks are only gated, never reset, so contents survive stop
   always @(posedge i_core_clk or negedge i_external_reset_pin) begin
      if (!i_external_reset_pin) begin
         o_core_halt     <= 1'b0;
         o_core_clk_en   <= 1'b1;
         o_periph_clk_en <= 1'b1;
      end else begin
         o_core_halt     <= core_halt_next;
         o_core_clk_en   <= core_clk_en_next;
         o_periph_clk_en <= periph_clk_en_next;
      end
   end

   // oscillators and multiplier
   always @(posedge i_core_clk or negedge i_external_reset_pin) begin
      if (!i_external_reset_pin) begin
         o_pll_en                  <= 1'b1;
         o_internal_rc_osc_en      <= 1'b1;
         o_external_crystal_osc_en <= 1'b1;
      end else begin
         o_pll_en                  <= pll_en_next;
         o_internal_rc_osc_en      <= rc_osc_en_next;
         o_external_crystal_osc_en <= xtal_osc_en_next;
      end
   end

   // regulator and core-domain reset
   always @(posedge i_core_clk or negedge i_external_reset_pin) begin
      if (!i_external_reset_pin) begin
         o_core_reg_on     <= 1'b1;
         o_core_reg_lp     <= 1'b0;
         o_core_domain_rst <= 1'b0;
      end else begin
         o_core_reg_on     <= core_reg_on_next;
         o_core_reg_lp     <= core_reg_lp_next;
         // core domain restarts from reset after standby
         o_core_domain_rst <= dom_rst_next;
      end
   end

   // always-on domain and status; rtc and watchdog clocks have no off state
   always @(posedge i_core_clk or negedge i_external_reset_pin) begin
      if (!i_external_reset_pin) begin
         o_rtc_wdg_clk_en <= 1'b1;
         o_state          <= `LPMS_ST_RUN;
         o_standby_flag   <= 1'b0;
      end else begin
         o_rtc_wdg_clk_en <= 1'b1;
         o_state          <= state_next;
         o_standby_flag   <= standby_flag_next;
      end
   end
endmodule // lpms_top

// *** lpms_consts.vh ***
`ifndef LPMS_CONSTS_VH
`define LPMS_CONSTS_VH
`define LPMS_MODE_SLEEP     2'h0
`define LPMS_MODE_STOP      2'h1
`define LPMS_MODE_STANDBY   2'h2
`define LPMS_ST_RUN         3'h0
`define LPMS_ST_SLEEP       3'h1
`define LPMS_ST_STOP        3'h2
`define LPMS_ST_STANDBY     3'h3
`define LPMS_ST_WAKE        3'h4
`define LPMS_EXT_LINES      16
`define LPMS_EVT_LINES      19
`define LPMS_BKP_WORDS      42
`define LPMS_BKP_AW         6
`define LPMS_BKP_DW         16
`define LPMS_WAKE_CYC       4'h3
`endif

// *** lpms_bkp_mem.v ***
`timescale 1ns/1ns
`include "lpms_consts.vh"
// backup register array; has no reset so no system reset clears it
module lpms_bkp_mem #(
   parameter DEPTH = `LPMS_BKP_WORDS,
   parameter AW    = `LPMS_BKP_AW,
   parameter DW    = `LPMS_BKP_DW
) (
   input  wire          i_core_clk,
   input  wire          i_wr_en,
   input  wire [AW-1:0] i_addr,
   input  wire [DW-1:0] i_wdata,
   output reg  [DW-1:0] o_rdata
);
   reg [DW-1:0] mem_reg [0:DEPTH-1];

   // writes beyond depth are dropped, reads give zero
   always @(posedge i_core_clk) begin
      if (i_wr_en && (i_addr < DEPTH)) begin
         mem_reg[i_addr] <= i_wdata;
      end
      if (i_addr < DEPTH) begin
         o_rdata <= mem_reg[i_addr];
      end else begin
         o_rdata <= {DW{1'b0}};
      end
   end
endmodule // lpms_bkp_mem

// *** lpms_edge.v ***
`timescale 1ns/1ns
// rising-edge detector for one input
module lpms_edge (
   input  wire i_core_clk,
   input  wire i_external_reset_pin,
   input  wire i_lvl,
   output wire o_rise
);
   reg prev_reg;

   always @(posedge i_core_clk or negedge i_external_reset_pin) begin
      if (!i_external_reset_pin) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= i_lvl;
      end
   end
   assign o_rise = i_lvl & ~prev_reg;
endmodule // lpms_edge

// *** lpms_properties.sv ***
`timescale 1ns/1ns
// ------------------------------
// mode sequencing checks
// ------------------------------
module lpms_props #(
   parameter NEXT = 16
) (
   // clock and reset
   input wire            i_core_clk,
   input wire            i_external_reset_pin,
   // core request and configuration
   input wire            i_sleep_req,
   input wire [1:0]      i_mode_sel,
   input wire            i_stop_lp_reg,
   input wire            i_periph_irq,
   // wake sources
   input wire [NEXT-1:0] i_ext_lines,
   input wire            i_supply_voltage_detector,
   input wire            i_rtc_alarm,
   input wire            i_usb_wakeup,
   input wire            i_external_reset_pin_n,
   input wire            i_independent_watchdog_rst,
   input wire            i_wakeup_pin,
   // power and clock controls
   input wire            o_core_halt,
   input wire            o_core_clk_en,
   input wire            o_periph_clk_en,
   input wire            o_pll_en,
   input wire            o_internal_rc_osc_en,
   input wire            o_external_crystal_osc_en,
   input wire            o_core_reg_on,
   input wire            o_core_reg_lp,
   input wire            o_core_domain_rst,
   input wire            o_rtc_wdg_clk_en,
   input wire            o_standby_flag,
   input wire [2:0]      o_state
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_external_reset_pin);
   a_sleep_core_only: assert property (
      o_state == 3'h1 |-> o_core_halt && o_periph_clk_en && o_pll_en)
      else $error("sleep stopped more than the core");
   a_sleep_irq_wake: assert property (
      o_state == 3'h1 && i_periph_irq |=> o_state == 3'h0)
      else $error("interrupt did not resume core");
   a_stop_clk_gate: assert property (
      o_state == 3'h2 |-> !o_core_clk_en && !o_periph_clk_en)
      else $error("core clocks run in stop");
   a_stop_osc_off: assert property (
      o_state == 3'h2 |-> !(o_pll_en || o_internal_rc_osc_en || o_external_crystal_osc_en))
      else $error("oscillator left on in stop");
   a_stop_reg_sel: assert property (
      o_state == 3'h0 && i_sleep_req && i_mode_sel == 2'h1
      |=> o_core_reg_on && o_core_reg_lp == $past(i_stop_lp_reg))
      else $error("stop regulator setting wrong");
   a_stop_evt_wake: assert property (
      o_state == 3'h2 && (|i_ext_lines || i_supply_voltage_detector || i_rtc_alarm
      || i_usb_wakeup) |=> o_state == 3'h4 ##4 o_state == 3'h0)
      else $error("event line wake sequence wrong");
   a_stby_power_off: assert property (
      o_state == 3'h3 |-> !o_core_reg_on && o_core_domain_rst
      && o_standby_flag && !o_pll_en && !o_external_crystal_osc_en)
      else $error("standby power state wrong");
   a_stby_wake_off: assert property (
      o_state == 3'h3 && i_rtc_alarm |=> !o_core_reg_on && o_core_domain_rst)
      else $error("core domain powered during standby wake");
   a_stby_exit_src: assert property (
      o_state == 3'h3 && (!i_external_reset_pin_n || i_independent_watchdog_rst
      || i_rtc_alarm || $rose(i_wakeup_pin)) |=> o_state == 3'h4)
      else $error("standby exit missed");
   a_stby_hold: assert property (
      o_state == 3'h3 && i_external_reset_pin_n && !i_independent_watchdog_rst
      && !i_rtc_alarm && !$rose(i_wakeup_pin) |=> $stable(o_state))
      else $error("standby left without exit source");
   a_flag_clear: assert property (
      o_state == 3'h0 && i_sleep_req && i_mode_sel != 2'h2 |=> !o_standby_flag)
      else $error("standby flag not cleared by request");
   a_rtc_always: assert property (
      o_rtc_wdg_clk_en)
      else $error("rtc clock stopped");
endmodule // lpms_props

bind lpms_top lpms_props #(.NEXT(NEXT)) u_props (.*);

// *** lpms_core_model.sv ***
`timescale 1ns/1ns
// ------------------------------
// core side: requests only from run
// ------------------------------
module lpms_core_model (
   input  wire       i_core_clk,
   input  wire       i_go,
   input  wire [1:0] i_mode,
   input  wire [2:0] i_state,
   output reg        o_sleep_req,
   output reg  [1:0] o_mode_sel
);
   initial begin
      o_sleep_req = 1'b0;
      o_mode_sel = 2'h0;
   end
   always @(negedge i_core_clk) begin
      o_mode_sel <= i_mode;
      o_sleep_req <= i_go && (i_state == 3'h0);
   end
endmodule // lpms_core_model

// *** lpms_top_bench.sv ***
`timescale 1ns/1ns
module lpms_top_bench;
   reg clk = 0, external_reset_pin = 0, go = 0, irq = 0, lp = 0, rpn = 1, wdg = 0, wkp = 0, bwr = 0;
   reg  [1:0]  md = 0;
   reg  [18:0] wk = 0;
   reg  [5:0]  ba = 0;
   reg  [15:0] bd = 0;
   wire        req, halt, cce, pce, pll, rc, xo, ron, rlp, drst, rtc, flg;
   wire [1:0]  ms;
   wire [2:0]  st;
   wire [15:0] rd;
   integer     failures = 0, tests_run = 0;
   // ------------------------------
   // harness
   // ------------------------------
   lpms_top u_dut (.i_core_clk(clk), .i_external_reset_pin(external_reset_pin), .i_sleep_req(req), .i_mode_sel(ms),
      .i_stop_lp_reg(lp), .i_periph_irq(irq), .i_ext_lines(wk[15:0]),
      .i_supply_voltage_detector(wk[16]), .i_rtc_alarm(wk[17]), .i_usb_wakeup(wk[18]),
      .i_external_reset_pin_n(rpn), .i_independent_watchdog_rst(wdg), .i_wakeup_pin(wkp),
      .i_bkp_wr(bwr), .i_bkp_addr(ba), .i_bkp_wdata(bd), .o_bkp_rdata(rd), .o_core_halt(halt),
      .o_core_clk_en(cce), .o_periph_clk_en(pce), .o_pll_en(pll), .o_internal_rc_osc_en(rc),
      .o_external_crystal_osc_en(xo), .o_core_reg_on(ron), .o_core_reg_lp(rlp),
      .o_core_domain_rst(drst), .o_rtc_wdg_clk_en(rtc), .o_state(st), .o_standby_flag(flg));
   lpms_core_model u_core (.i_core_clk(clk), .i_go(go), .i_mode(md), .i_state(st),
      .o_sleep_req(req), .o_mode_sel(ms));
   initial begin
      forever #50 clk = ~clk;
   end
   task give_verdict;
      begin
         if (failures == 0 && tests_run > 0) $display("Testbench passed");
         else $display("Testbench failed");
         $finish;
      end
   endtask
   task chk(input [15:0] v, input [15:0] e, input [63:0] n);
      begin
         tests_run = tests_run + 1;
         if (v !== e) begin
            failures = failures + 1;
            $display("[ERR] %s exp %h got %h", n, e, v);
         end
      end
   endtask
   task enter(input [1:0] m);
      integer k;
      begin
         md <= m;
         go <= 1'b1;
         for (k = 0; k < 5 && st === 3'h0; k = k + 1) @(negedge clk);
         go <= 1'b0;
      end
   endtask
   // wake always lasts four cycles before run
   task wake;
      begin
         @(negedge clk);
         wk <= 19'h0;
         rpn <= 1'b1;
         wdg <= 1'b0;
         wkp <= 1'b0;
         chk({st, pll, rc, xo}, 6'h23, "wake");
         repeat (3) @(negedge clk);
         chk(st, 3'h4, "wake4");
         @(negedge clk);
         chk(st, 3'h0, "run");
         chk({halt, cce, pce, pll, rc, xo, ron, drst}, 8'h7e, "runout");
      end
   endtask
   task bkp(input w);
      integer k;
      begin
         for (k = 0; k < 43; k = k + 1) begin
            ba <= k[5:0];
            bd <= {2{2'h2, k[5:0]}};
            bwr <= w;
            @(negedge clk);
            if (!w) chk(rd, k < 42 ? {2{2'h2, k[5:0]}} : 16'h0, "bkp");
         end
         bwr <= 1'b0;
         @(negedge clk);
      end
   endtask
   task t_sleep;
      integer m;
      begin
         for (m = 0; m < 4; m = m + 3) begin
            enter(m[1:0]);
            chk({st, halt, pce, pll}, {3'h1, 3'b111}, "sleep");
            chk(flg, 1'b0, "flagclr");
            if (m == 0) irq <= 1'b1;
            else wk <= 19'h40000;
            @(negedge clk);
            irq <= 1'b0;
            wk <= 19'h0;
            chk(st, 3'h0, "irqwake");
         end
      end
   endtask
   task t_stop;
      integer s;
      begin
         for (s = 0; s < 19; s = s + 1) begin
            lp <= s[0];
            enter(2'h1);
            chk({halt, cce, pce, pll, rc, xo, ron, rlp}, {7'b1000001, s[0]}, "stop");
            wk <= 19'h1 << s;
            wake;
         end
      end
   endtask
   task t_stby;
      integer s;
      begin
         for (s = 0; s < 4; s = s + 1) begin
            enter(2'h2);
            chk({ron, drst, flg, pll, rc, xo, rtc}, 7'b0110001, "stby");
            wk <= 19'h0ffff;
            @(negedge clk);
            chk(st, 3'h3, "stay");
            wk <= (s == 3) ? 19'h20000 : 19'h0;
            if (s == 0) rpn <= 1'b0;
            if (s == 1) wdg <= 1'b1;
            if (s == 2) wkp <= 1'b1;
            wake;
         end
      end
   endtask
   initial begin
      repeat (10) @(negedge clk);
      external_reset_pin <= 1'b1;
      @(negedge clk);
      bkp(1'b1);
      t_sleep;
      t_stop;
      external_reset_pin <= 1'b0;
      @(negedge clk);
      external_reset_pin <= 1'b1;
      @(negedge clk);
      t_stby;
      t_sleep;
      bkp(1'b0);
      give_verdict;
   end
   initial begin
      repeat (3000) @(negedge clk);
      failures = failures + 1;
      give_verdict;
   end
endmodule // lpms_top_bench
